/* hw/smc_heartbeat.sv */
// heartbeat divider: one-cycle pulse per heartbeat transition
`timescale 1ns/1ps
`default_nettype none
module smc_heartbeat import smc_pkg::*; #(
    parameter int HB_DIV = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // heartbeat transition pulse
    output logic tick
);
    // all state in one struct
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } smc_hb_t;
    smc_hb_t st, next_st;

    // free-running divider
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == 16'(HB_DIV - 1)) begin
            next_st.cnt = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{cnt: 16'h0000, tick: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule
`default_nettype wire

/* hw/smc_pkg.sv */
// shared constants and carrier types for the sensor mode controller
package smc_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] SMC_ADDR_INIT = 8'h0F;
    localparam logic [7:0] SMC_ADDR_MODE = 8'h10;
    localparam logic [7:0] SMC_ADDR_STATUS = 8'h08;
    localparam logic [7:0] SMC_ADDR_COUNT = 8'h29;
    // start-up register values
    localparam logic [7:0] SMC_INIT_KEY = 8'h42;
    localparam logic [7:0] SMC_INIT_BUSY = 8'h45;
    localparam logic [7:0] SMC_INIT_READY = 8'h40;
    localparam logic [7:0] SMC_INIT_DONE = 8'h43;
    // reset values and the endless count
    localparam logic [7:0] SMC_MODE_RESET = 8'h00;
    localparam logic [7:0] SMC_COUNT_RESET = 8'h01;
    localparam logic [7:0] SMC_COUNT_FOREVER = 8'hFF;
    localparam logic [7:0] SMC_ZERO = 8'h00;
    // mode register field positions
    localparam int SMC_COUNTED_ACQUISITION_MODE_BIT = 7;
    localparam int SMC_PD_LO = 4;
    localparam int SMC_NUM_AXES = 3;
    // heartbeat: transitions allowed for a mode change
    localparam int SMC_HB_TRANSITIONS = 3;
    // operating modes
    typedef enum logic [2:0] {
        SMC_SLEEP = 3'b000,
        SMC_STANDBY = 3'b001,
        SMC_SNIFF = 3'b010,
        SMC_RSV3 = 3'b011,
        SMC_RSV4 = 3'b100,
        SMC_CONTINUOUS_SAMPLING_MODE = 3'b101,
        SMC_COMBINED_WATCH_SAMPLING_MODE = 3'b110,
        SMC_COUNTED_ACQUISITION_MODE = 3'b111
    } smc_mode_t;
    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smc_req_t;
    // block enables presented to the datapath
    typedef struct packed {
        logic clocks_on;
        logic sniff_on;
        logic sample_on;
        logic fifo_on;
        logic [2:0] axis_on;
    } smc_ctl_t;
endpackage

/* hw/smc_startup.sv */
// start-up sequencer: counts out the internal start-up time
`timescale 1ns/1ps
`default_nettype none
module smc_startup import smc_pkg::*; #(
    parameter int STARTUP_CYCLES = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // status
    output logic busy
);
    // all state in one struct
    typedef struct packed {
        logic [15:0] cnt;
        logic busy;
    } smc_su_t;
    smc_su_t st, next_st;

    // count the start-up time up from zero after reset
    always_comb begin
        next_st = st;
        if (st.busy) begin
            if (st.cnt == 16'(STARTUP_CYCLES - 1)) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.cnt = st.cnt + 16'h0001;
            end
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{cnt: 16'h0000, busy: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.busy;
endmodule
`default_nettype wire

/* hw/smc_top.sv */
// mode control register bank with start-up register and mode sequencer
//
// How it works
// - init reads 0x45 busy, then 0x40
// - after host writes the 0x42 key, init reads 0x43
// - mode change completes within three heartbeats
// - hardware may rewrite the mode field
// - 000 sleep, clocks stopped
// - 001 standby, clocks on, no sampling
// - 010 sniff, auto switch to wake
// - 101 continuous wake, sniff off
// - 110 sniff, sampling and fifo together
// - 111 counted acquisition, then back to sleep unless the count is 0xFF
// - bits 4..6 power down axes
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module smc_top import smc_pkg::*; #(
    parameter int STARTUP_CYCLES = 64,
    parameter int HB_DIV = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // datapath events
    input wire logic activity,
    input wire logic sample_done,
    // datapath control
    output smc_ctl_t ctl,
    output smc_mode_t mode_now
);
    // all state in one struct
    typedef struct packed {
        logic init_written;     // host wrote the start-up key
        smc_mode_t mode_field;  // requested mode, may move by hardware
        logic [2:0] axis_pd;    // per-axis power-down
        smc_mode_t mode_eff;    // mode in force (status field)
        logic [1:0] hb_cnt;     // heartbeats since change was requested
        logic pending;          // a mode change is waiting
        logic [7:0] count;      // acquisition sample count
        logic [7:0] taken;      // samples taken in counted mode
        logic [7:0] rdata;      // read data register
        logic [7:0] pend_age;   // cycles the pending change has waited
    } smc_st_t;
    smc_st_t st, next_st;

    // longest wait a mode change may see: three heartbeat periods
    localparam logic [7:0] AGE_LIMIT = 8'(SMC_HB_TRANSITIONS * HB_DIV);
    // saturation point of the wait counter, so it never wraps to zero
    localparam logic [7:0] AGE_MAX = 8'hFF;

    // request carried as one bundle
    smc_req_t req;
    // start-up and heartbeat helpers
    logic su_busy;
    logic hb_tick;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // internal start-up timer
    smc_startup #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_startup (
        .clk(clk),
        .srst(srst),
        .busy(su_busy)
    );

    // heartbeat clock as a pulse train
    smc_heartbeat #(.HB_DIV(HB_DIV)) u_heartbeat (
        .clk(clk),
        .srst(srst),
        .tick(hb_tick)
    );

    // next-state logic for the whole bank
    always_comb begin
        next_st = st;
        // read path: data valid the cycle after the strobe
        next_st.rdata = SMC_ZERO;
        if (req.rd) begin
            case (req.addr)
                SMC_ADDR_INIT: begin
                    if (su_busy) begin
                        next_st.rdata = SMC_INIT_BUSY;
                    end else if (st.init_written) begin
                        next_st.rdata = SMC_INIT_DONE;
                    end else begin
                        next_st.rdata = SMC_INIT_READY;
                    end
                end
                SMC_ADDR_STATUS: begin
                    next_st.rdata = {5'h00, st.mode_eff}; // status mode field
                end
                SMC_ADDR_COUNT: begin
                    next_st.rdata = st.count;
                end
                default: begin
                    next_st.rdata = SMC_ZERO; // unmapped or write-only reads zero
                end
            endcase
        end
        // heartbeat counting of a pending change
        if (st.pending && hb_tick && st.hb_cnt != 2'(SMC_HB_TRANSITIONS - 1)) begin
            next_st.hb_cnt = st.hb_cnt + 2'b01;
        end
        // apply pending change on the last allowed heartbeat
        if (st.pending && hb_tick && st.hb_cnt == 2'(SMC_HB_TRANSITIONS - 1)) begin
            next_st.mode_eff = st.mode_field;
            next_st.pending = 1'b0;
            next_st.taken = SMC_ZERO;
        end
        // hardware-driven transitions while a mode is in force
        if (!st.pending) begin
            case (st.mode_eff)
                SMC_SNIFF: begin
                    if (activity) begin
                        next_st.mode_field = SMC_CONTINUOUS_SAMPLING_MODE;
                        next_st.mode_eff = SMC_CONTINUOUS_SAMPLING_MODE;
                    end
                end
                SMC_COUNTED_ACQUISITION_MODE: begin
                    if (sample_done && st.count != SMC_COUNT_FOREVER) begin
                        if (st.taken + 8'h01 >= st.count) begin
                            next_st.mode_field = SMC_SLEEP;
                            next_st.mode_eff = SMC_SLEEP;
                        end else begin
                            next_st.taken = st.taken + 8'h01;
                        end
                    end
                end
                default: begin
                    next_st.taken = st.taken;
                end
            endcase
        end
        // host writes
        if (req.wr) begin
            case (req.addr)
                SMC_ADDR_INIT: begin
                    if (req.wdata == SMC_INIT_KEY) begin
                        next_st.init_written = 1'b1;
                    end
                end
                SMC_ADDR_MODE: begin
                    next_st.axis_pd = req.wdata[SMC_PD_LO +: SMC_NUM_AXES];
                    next_st.hb_cnt = 2'b00;
                    next_st.pending = 1'b1;
                    if (req.wdata[SMC_COUNTED_ACQUISITION_MODE_BIT] && st.mode_eff == SMC_STANDBY) begin
                        next_st.mode_field = SMC_COUNTED_ACQUISITION_MODE;
                    end else begin
                        next_st.mode_field = smc_mode_t'(req.wdata[2:0]);
                    end
                end
                SMC_ADDR_COUNT: begin
                    next_st.count = req.wdata;
                end
                default: begin
                    next_st.count = next_st.count; // unmapped writes ignored
                end
            endcase
        end
        // cycles a change has waited; a new mode write starts the count again
        if ((req.wr && req.addr == SMC_ADDR_MODE) || !next_st.pending) begin
            next_st.pend_age = SMC_ZERO;
        end else if (st.pend_age != AGE_MAX) begin
            next_st.pend_age = st.pend_age + 8'h01;
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (srst) begin
            st.init_written <= 1'b0;
            st.mode_field <= smc_mode_t'(SMC_MODE_RESET[2:0]);
            st.axis_pd <= SMC_MODE_RESET[SMC_PD_LO +: SMC_NUM_AXES];
            st.mode_eff <= SMC_SLEEP;
            st.hb_cnt <= 2'b00;
            st.pending <= 1'b0;
            st.count <= SMC_COUNT_RESET;
            st.taken <= SMC_ZERO;
            st.rdata <= SMC_ZERO;
            st.pend_age <= SMC_ZERO;
        end else begin
            st <= next_st;
        end
    end

    // block enables decoded from the mode in force
    always_comb begin
        ctl = '0;
        case (st.mode_eff)
            SMC_SLEEP: begin
                ctl = '0;
            end
            SMC_STANDBY: begin
                ctl.clocks_on = 1'b1;
            end
            SMC_SNIFF: begin
                ctl.clocks_on = 1'b1;
                ctl.sniff_on = 1'b1;
            end
            SMC_CONTINUOUS_SAMPLING_MODE: begin
                ctl.clocks_on = 1'b1;
                ctl.sample_on = 1'b1;
            end
            SMC_COMBINED_WATCH_SAMPLING_MODE: begin
                ctl.clocks_on = 1'b1;
                ctl.sniff_on = 1'b1;
                ctl.sample_on = 1'b1;
                ctl.fifo_on = 1'b1;
            end
            SMC_COUNTED_ACQUISITION_MODE: begin
                ctl.clocks_on = 1'b1;
                ctl.sample_on = 1'b1;
            end
            default: begin
                ctl.clocks_on = 1'b1; // reserved codes behave as standby
            end
        endcase
        if (ctl.sample_on) begin
            ctl.axis_on = ~st.axis_pd;
        end
    end

    assign rdata = st.rdata;
    assign mode_now = st.mode_eff;

    // mode change lands within three heartbeats
    property p_hb;
        @(posedge clk) disable iff (srst)
        (st.pending && hb_tick && st.hb_cnt == 2'(SMC_HB_TRANSITIONS - 1) && !req.wr)
            |=> (mode_now == $past(st.mode_field)) && !st.pending;
    endproperty
    mode_change_a: assert property (p_hb) else $error("mode change late");

    // start-up read value while the sequencer still runs
    init_busy_a: assert property (@(posedge clk) disable iff (srst)
        (rd && addr == SMC_ADDR_INIT && su_busy) |=> rdata == SMC_INIT_BUSY)
        else $error("init busy value wrong");

    // start-up read value once the sequencer is done and no key came
    init_ready_a: assert property (@(posedge clk) disable iff (srst)
        (rd && addr == SMC_ADDR_INIT && !su_busy && !st.init_written)
            |=> rdata == SMC_INIT_READY)
        else $error("init ready value wrong");

    // read-back after the key, never the key itself
    init_done_a: assert property (@(posedge clk) disable iff (srst)
        (rd && addr == SMC_ADDR_INIT && !su_busy && st.init_written)
            |=> rdata == SMC_INIT_DONE)
        else $error("init done value wrong");

    // a change must not wait past three heartbeat periods
    pend_age_a: assert property (@(posedge clk) disable iff (srst)
        st.pend_age < AGE_LIMIT)
        else $error("mode change took too long");

    // activity in sniff hands over to continuous wake at once
    sniff_wake_a: assert property (@(posedge clk) disable iff (srst)
        (mode_now == SMC_SNIFF && !st.pending && activity && !wr)
            |=> mode_now == SMC_CONTINUOUS_SAMPLING_MODE && ctl.sample_on && !ctl.sniff_on)
        else $error("sniff did not wake");

    // sleep keeps every block off
    sleep_off_a: assert property (@(posedge clk) disable iff (srst)
        mode_now == SMC_SLEEP |-> ctl == '0)
        else $error("sleep not quiet");

    // standby runs clocks but takes no samples
    standby_idle_a: assert property (@(posedge clk) disable iff (srst)
        mode_now == SMC_STANDBY |-> ctl.clocks_on && !ctl.sample_on)
        else $error("standby sampling");

    // continuous wake samples with the sniff path off
    continuous_sampling_mode_run_a: assert property (@(posedge clk) disable iff (srst)
        mode_now == SMC_CONTINUOUS_SAMPLING_MODE |-> ctl.clocks_on && ctl.sample_on && !ctl.sniff_on)
        else $error("continuous wake wrong");

    // combined mode runs sniff, sampling and fifo together
    combined_watch_sampling_mode_all_a: assert property (@(posedge clk) disable iff (srst)
        mode_now == SMC_COMBINED_WATCH_SAMPLING_MODE |-> ctl.sniff_on && ctl.sample_on && ctl.fifo_on)
        else $error("combined mode incomplete");

    // counted acquisition samples with the sniff path off
    counted_acquisition_mode_sample_a: assert property (@(posedge clk) disable iff (srst)
        mode_now == SMC_COUNTED_ACQUISITION_MODE |-> ctl.clocks_on && ctl.sample_on && !ctl.sniff_on)
        else $error("acquisition not sampling");

    // an endless count never drops back to sleep
    counted_acquisition_mode_forever_a: assert property (@(posedge clk) disable iff (srst)
        (mode_now == SMC_COUNTED_ACQUISITION_MODE && !st.pending && st.count == SMC_COUNT_FOREVER && !wr)
            |=> mode_now == SMC_COUNTED_ACQUISITION_MODE)
        else $error("endless acquisition stopped");

    // axis power-down bits land with every mode write
    axis_pd_a: assert property (@(posedge clk) disable iff (srst)
        (wr && addr == SMC_ADDR_MODE)
            |=> st.axis_pd == $past(wdata[SMC_PD_LO +: SMC_NUM_AXES]))
        else $error("axis power-down not stored");

    // reset leaves sleep with all axes enabled
    reset_mode_a: assert property (@(posedge clk)
        srst |=> mode_now == SMC_SLEEP && st.axis_pd == 3'b000)
        else $error("reset mode wrong");
endmodule
`default_nettype wire

/* tb/smc_datapath_model.sv */
// datapath model: raises activity on request and paces samples while sampling runs
`timescale 1ns/1ps
`default_nettype none
module smc_datapath_model import smc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control from the block and the bench
    input wire smc_ctl_t ctl,
    input wire logic act_req,
    // events back to the block
    output logic activity,
    output logic sample_done
);
    logic [1:0] pace; // sample pacing counter
    // one sample pulse every fourth cycle while sampling is enabled
    always_ff @(posedge clk) begin
        if (srst || !ctl.sample_on) begin
            pace <= 2'h0;
            sample_done <= 1'b0;
        end else begin
            pace <= pace + 2'h1;
            sample_done <= (pace == 2'h3);
        end
        activity <= act_req & !srst; // motion seen by the sniff path
    end
endmodule
`default_nettype wire

/* tb/smc_top_bench.sv */
// self-checking bench for the mode control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module smc_top_bench import smc_pkg::*;;
    localparam int HB = 4; // shortened heartbeat divider
    localparam int WAIT_MAX = 3 * HB + 2; // three heartbeats plus sampling slack, not four
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic act_req = 1'b0;
    logic [7:0] rdata;
    logic activity;
    logic sample_done;
    smc_ctl_t ctl;
    smc_mode_t mode_now;
    int failures = 0;
    int n_tests = 0;
    logic [7:0] v;
    logic [7:0] n_samp; // sample pulses seen since reset
    logic [7:0] s0; // sample pulses seen when an acquisition starts
    // mode table: code, axis powerdown, expected {clocks, sniff, sample, fifo}
    logic [2:0] tm [4] = '{3'b001, 3'b101, 3'b110, 3'b000};
    logic [2:0] tp [4] = '{3'b000, 3'b101, 3'b010, 3'b111};
    logic [3:0] te [4] = '{4'b1000, 4'b1010, 4'b1111, 4'b0000};
    // 125 MHz clock
    always #4 clk = ~clk;
    smc_top #(.STARTUP_CYCLES(8), .HB_DIV(HB)) dut (
        .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .activity(activity), .sample_done(sample_done),
        .ctl(ctl), .mode_now(mode_now));
    smc_datapath_model dpm (
        .clk(clk), .srst(srst), .ctl(ctl), .act_req(act_req),
        .activity(activity), .sample_done(sample_done));
    // count sample pulses from the datapath model
    always @(posedge clk) begin
        if (srst) begin
            n_samp <= 8'h00;
        end else if (sample_done) begin
            n_samp <= n_samp + 8'h01;
        end
    end
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one-cycle write strobe
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken the cycle after
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // bounded wait for the mode in force
    task automatic wait_mode(input smc_mode_t m);
        int i;
        #1;
        for (i = 0; i < WAIT_MAX && mode_now !== m; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK(mode_now, m)
    endtask
    // control outputs for a mode, axis enables only when sampling
    task automatic chk_ctl(input logic [3:0] e, input logic [2:0] pd);
        `CHK({ctl.clocks_on, ctl.sniff_on, ctl.sample_on, ctl.fifo_on}, e)
        if (e[1]) begin
            `CHK(ctl.axis_on, ~pd)
        end
    endtask
    // hang guard
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        reg_rd(SMC_ADDR_INIT, v);
        `CHK(v, 8'h45)
        `CHK(mode_now, SMC_SLEEP)
        `CHK(ctl, '0)
        reg_rd(SMC_ADDR_STATUS, v);
        `CHK(v, 8'h00)
        repeat (10) @(posedge clk);
        reg_rd(SMC_ADDR_INIT, v);
        `CHK(v, 8'h40)
        reg_wr(SMC_ADDR_INIT, 8'h41);
        reg_rd(SMC_ADDR_INIT, v);
        `CHK(v, 8'h40)
        reg_wr(SMC_ADDR_INIT, 8'h42);
        reg_rd(SMC_ADDR_INIT, v);
        `CHK(v, 8'h43)
        // four mode and axis settings in turn
        for (int k = 0; k < 4; k++) begin
            reg_wr(SMC_ADDR_MODE, {1'b0, tp[k], 1'b0, tm[k]});
            wait_mode(smc_mode_t'(tm[k]));
            chk_ctl(te[k], tp[k]);
            reg_rd(SMC_ADDR_STATUS, v);
            `CHK(v, {5'h00, tm[k]})
        end
        // sniff hands over to continuous wake on activity
        reg_wr(SMC_ADDR_MODE, 8'h02);
        wait_mode(SMC_SNIFF);
        chk_ctl(4'b1100, 3'b000);
        @(posedge clk);
        act_req <= 1'b1;
        wait_mode(SMC_CONTINUOUS_SAMPLING_MODE);
        chk_ctl(4'b1010, 3'b000);
        @(posedge clk);
        act_req <= 1'b0;
        reg_rd(SMC_ADDR_STATUS, v);
        `CHK(v, 8'h05)
        // one-shot counted acquisition from standby, then back to sleep
        reg_wr(SMC_ADDR_MODE, 8'h01);
        wait_mode(SMC_STANDBY);
        reg_wr(SMC_ADDR_COUNT, 8'h02);
        reg_rd(SMC_ADDR_COUNT, v);
        `CHK(v, 8'h02)
        s0 = n_samp;
        reg_wr(SMC_ADDR_MODE, 8'h81);
        wait_mode(SMC_COUNTED_ACQUISITION_MODE);
        wait_mode(SMC_SLEEP);
        `CHK(n_samp - s0, 8'h02)
        // counted mode by mode field with endless count stays sampling
        reg_wr(SMC_ADDR_COUNT, SMC_COUNT_FOREVER);
        reg_wr(SMC_ADDR_MODE, 8'h07);
        wait_mode(SMC_COUNTED_ACQUISITION_MODE);
        repeat (40) @(posedge clk);
        #1;
        `CHK(mode_now, SMC_COUNTED_ACQUISITION_MODE)
        `CHK(ctl.sample_on, 1'b1)
        // reset in mid-run: sleep again, start-up reruns, key forgotten
        @(posedge clk);
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        reg_rd(SMC_ADDR_INIT, v);
        `CHK(v, 8'h45)
        `CHK(mode_now, SMC_SLEEP)
        `CHK(ctl, '0)
        reg_rd(SMC_ADDR_COUNT, v);
        `CHK(v, SMC_COUNT_RESET)
        repeat (10) @(posedge clk);
        reg_rd(SMC_ADDR_INIT, v);
        `CHK(v, 8'h40)
        reg_wr(SMC_ADDR_INIT, 8'h42);
        reg_rd(SMC_ADDR_INIT, v);
        `CHK(v, 8'h43)
        end_of_test();
    end
endmodule
`default_nettype wire
